// ==== verilog/hps_pkg.sv ====
// Constants, types and register map of the host power supervisor
// Summary of operation
// [RULE1] Missed keep-alive while supervising power-cycles host
// [RULE2] Host sends keep-alive at a regular interval
// [RULE3] Bit 7 at 0x35 enables supervision
// [RULE4] Drive two fan channels, joint or separate
// [RULE5] Joint mode: 0x84 sets both, 0x85 ignored
// [RULE6] Missing fans never gate other functions
// [RULE7] Host off at power-up: indicators flash alternately
// [RULE8] Setting 0x03 powers host on at supply-up
// [RULE9] Low seven bits hold maximum reboot attempts
// [RULE10] Any write to 0x82 restarts supervision timeout
// [RULE11] 0x34: bit0 clear none, 01 conditional, 11 always
// [RULE12] Reset: fans full speed, joint; clear bit separates
package hps_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PWM_STEP_NS = 10000;
  localparam int unsigned PWM_STEP_CYCLES = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned WDT_TIMEOUT_MS = 30000;
  localparam int unsigned CYCLE_OFF_MS = 5000;
  localparam int unsigned FLASH_MS = 100;
  localparam logic [7:0] ADDR_FAN_MODE = 8'h30;
  localparam logic [7:0] ADDR_PWR_MGT = 8'h34;
  localparam logic [7:0] ADDR_SUPV = 8'h35;
  localparam logic [7:0] ADDR_STATUS = 8'h3f;
  localparam logic [7:0] ADDR_RESERVED = 8'h81;
  localparam logic [7:0] ADDR_KEEPALIVE = 8'h82;
  localparam logic [7:0] ADDR_BOOT_OK = 8'h83;
  localparam logic [7:0] ADDR_FAN0 = 8'h84;
  localparam logic [7:0] ADDR_FAN1 = 8'h85;
  localparam int unsigned SUPERVISION_ENABLE_BIT = 7;
  localparam int unsigned RESTORE_ENABLE_BIT = 0;
  localparam int unsigned RESTORE_ALWAYS_BIT = 1;
  localparam int unsigned FAN_JOINT_MODE_BIT = 0;
  localparam int unsigned BOOT_OFF_BIT = 0;
  localparam int unsigned FAN_PRESET_W = 3;
  localparam logic [7:0] PWR_MGT_RST = 8'h00;
  localparam logic [7:0] SUPV_RST = 8'h00;
  localparam logic FAN_JOINT_RST = 1'b1;
  localparam logic [2:0] FAN_PRESET_RST = 3'h4;
  localparam logic [7:0] READ_CMD_VAL = 8'hff;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [1:0] START_WAIT = 2'h3;

  typedef enum logic [2:0] {PWR_START, PWR_OFF, PWR_ON, PWR_CYCLE} hps_pwr_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hps_bus_s;

  typedef struct packed {
    logic fan0_pwm;
    logic fan1_pwm;
  } hps_fan_s;
endpackage

// ==== verilog/hps_divider.sv ====
// Free-running divider giving a one-cycle enable pulse
`timescale 1ns/100ps
module hps_divider #(
  parameter int unsigned CYCLES = 100
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Async reset, active high
  output logic tick_q // One-cycle enable pulse
);
  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } hps_div_s;
  hps_div_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == CW'(CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;
endmodule

// ==== verilog/hps_fan_pwm.sv ====
// Four-step PWM for one fan channel from a 3-bit speed preset
`timescale 1ns/100ps
module hps_fan_pwm
  import hps_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic step_en, // PWM step enable pulse
  input wire logic [FAN_PRESET_W-1:0] preset, // 0 off, 1..3 quarters, 1xx full
  output logic pwm_q // Fan drive, high while driving
);
  typedef struct packed {
    logic [1:0] cnt;
    logic pwm;
  } hps_pwm_s;
  hps_pwm_s s_q, s_d;
  logic [2:0] duty;

  always_comb begin
    duty = preset[2] ? 3'h4 : {1'b0, preset[1:0]};
    s_d = s_q;
    if (step_en) begin
      s_d.cnt = s_q.cnt + 2'h1;
      s_d.pwm = duty > {1'b0, s_q.cnt};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pwm_q = s_q.pwm;
endmodule

// ==== verilog/hps_supervisor.sv ====
// Host power supervisor: keep-alive timeout, power restore, fans, indicators
`timescale 1ns/100ps
module hps_supervisor
  import hps_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned TIMEOUT_TICKS = WDT_TIMEOUT_MS * 1000 / TICK_US,
  parameter int unsigned OFF_TICKS = CYCLE_OFF_MS * 1000 / TICK_US,
  parameter int unsigned FLASH_TICKS = FLASH_MS * 1000 / TICK_US
) (
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic reset, // Async reset, active high (supply applied)
  input wire hps_bus_s bus, // Register bus request
  output logic [7:0] bus_rdata, // Read data, cycle after read strobe
  input wire logic power_button, // Power button pin, high when pressed
  input wire logic last_on_pin, // Host was on before supply loss
  output logic host_power_on, // Host power switch, high = on
  output logic led_power, // Power indicator
  output logic led_boot, // Boot-ok indicator
  output hps_fan_s fan // Fan drives
);
  typedef struct packed {
    hps_pwr_e pwr;
    logic [31:0] wdt_cnt;
    logic [7:0] attempts;
    logic [31:0] off_cnt;
    logic [31:0] flash_cnt;
    logic flash_ph;
    logic [1:0] start_cnt;
    logic [7:0] pwr_mgt;
    logic [7:0] supv;
    logic fan_joint;
    logic [2:0] fan0;
    logic [2:0] fan1;
    logic boot_off;
    logic [7:0] rdata;
    logic btn_s1;
    logic btn_s2;
    logic btn_prev;
    logic last_s1;
    logic last_s2;
  } hps_state_s;

  localparam hps_state_s STATE_RST = '{
    pwr: PWR_START, wdt_cnt: '0, attempts: '0, off_cnt: '0, flash_cnt: '0,
    flash_ph: 1'b0, start_cnt: '0, pwr_mgt: PWR_MGT_RST, supv: SUPV_RST,
    fan_joint: FAN_JOINT_RST, fan0: FAN_PRESET_RST, fan1: FAN_PRESET_RST,
    boot_off: 1'b1, rdata: '0, btn_s1: 1'b0, btn_s2: 1'b0, btn_prev: 1'b0,
    last_s1: 1'b0, last_s2: 1'b0};

  hps_state_s s_q, s_d;
  logic tick;
  logic pwm_step;
  logic keepalive_wr;
  logic supv_on;
  logic timeout;
  logic [6:0] max_attempts;
  logic btn_press;

  hps_divider #(.CYCLES(TICK_DIV)) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_q(tick)
  );

  hps_divider #(.CYCLES(PWM_STEP_CYCLES)) u_pwm_step (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_q(pwm_step)
  );

  // Fans are plain outputs; an absent fan feeds nothing back into the block
  hps_fan_pwm u_fan0 ( // RULE4 RULE6
    .sys_clk(sys_clk),
    .reset(reset),
    .step_en(pwm_step),
    .preset(s_q.fan0),
    .pwm_q(fan.fan0_pwm)
  );

  hps_fan_pwm u_fan1 ( // RULE4
    .sys_clk(sys_clk),
    .reset(reset),
    .step_en(pwm_step),
    .preset(s_q.fan1),
    .pwm_q(fan.fan1_pwm)
  );

  assign keepalive_wr = bus.wr && bus.addr == ADDR_KEEPALIVE; // RULE10 RULE2
  assign supv_on = s_q.supv[SUPERVISION_ENABLE_BIT]; // RULE3
  assign max_attempts = s_q.supv[6:0]; // RULE9
  assign timeout = tick && s_q.wdt_cnt >= TIMEOUT_TICKS - 1;
  assign btn_press = s_q.btn_s2 && !s_q.btn_prev;

  always_comb begin
    s_d = s_q;
    s_d.btn_s1 = power_button;
    s_d.btn_s2 = s_q.btn_s1;
    s_d.btn_prev = s_q.btn_s2;
    s_d.last_s1 = last_on_pin;
    s_d.last_s2 = s_q.last_s1;
    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        ADDR_FAN_MODE: s_d.fan_joint = bus.wdata[FAN_JOINT_MODE_BIT]; // RULE12
        ADDR_PWR_MGT: s_d.pwr_mgt = bus.wdata;
        ADDR_SUPV: s_d.supv = bus.wdata; // RULE3 RULE9
        ADDR_BOOT_OK: s_d.boot_off = bus.wdata[BOOT_OFF_BIT];
        ADDR_FAN0: begin
          s_d.fan0 = bus.wdata[2:0];
          if (s_q.fan_joint) begin
            s_d.fan1 = bus.wdata[2:0]; // RULE5
          end
        end
        ADDR_FAN1: begin
          if (!s_q.fan_joint) begin // RULE5
            s_d.fan1 = bus.wdata[2:0];
          end
        end
        default: ;
      endcase
    end
    // Register reads; data stand only in the cycle after the strobe
    s_d.rdata = READ_UNMAPPED;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_FAN_MODE: s_d.rdata = {7'h00, s_q.fan_joint};
        ADDR_PWR_MGT: s_d.rdata = s_q.pwr_mgt;
        ADDR_SUPV: s_d.rdata = s_q.supv;
        ADDR_STATUS: s_d.rdata = {s_q.pwr == PWR_ON, s_q.attempts[6:0]};
        ADDR_RESERVED: s_d.rdata = READ_CMD_VAL;
        ADDR_KEEPALIVE: s_d.rdata = READ_CMD_VAL;
        ADDR_BOOT_OK: s_d.rdata = READ_CMD_VAL;
        ADDR_FAN0: s_d.rdata = {5'h00, s_q.fan0};
        ADDR_FAN1: s_d.rdata = {5'h00, s_q.fan1};
        default: s_d.rdata = READ_UNMAPPED;
      endcase
    end
    // Indicator flash phase runs whenever the host is off
    if (s_q.pwr != PWR_ON && tick) begin
      if (s_q.flash_cnt >= FLASH_TICKS - 1) begin
        s_d.flash_cnt = '0;
        s_d.flash_ph = !s_q.flash_ph; // RULE7
      end else begin
        s_d.flash_cnt = s_q.flash_cnt + 32'h0000_0001;
      end
    end
    // Keep-alive restarts the timeout and forgives earlier retries
    if (keepalive_wr || !supv_on) begin
      s_d.wdt_cnt = '0; // RULE10
      s_d.attempts = '0;
    end
    case (s_q.pwr)
      PWR_START: begin
        // Wait for the strap synchroniser to settle before deciding
        if (s_q.start_cnt == START_WAIT) begin
          if (s_q.pwr_mgt[RESTORE_ENABLE_BIT] &&
              (s_q.pwr_mgt[RESTORE_ALWAYS_BIT] || s_q.last_s2)) begin
            s_d.pwr = PWR_ON; // RULE8 RULE11
          end else begin
            s_d.pwr = PWR_OFF; // RULE11
          end
        end else begin
          s_d.start_cnt = s_q.start_cnt + 2'h1;
        end
      end
      PWR_OFF: begin
        if (btn_press) begin
          s_d.pwr = PWR_ON;
          s_d.wdt_cnt = '0;
        end
      end
      PWR_ON: begin
        if (supv_on && !keepalive_wr && tick) begin
          if (timeout) begin
            s_d.wdt_cnt = '0;
            s_d.off_cnt = '0;
            // First cycle happens once attempts are cleared; retries beyond the limit give up
            if (s_q.attempts <= {1'b0, max_attempts}) begin
              s_d.pwr = PWR_CYCLE; // RULE1
              s_d.attempts = s_q.attempts + 8'h01;
            end else begin
              s_d.pwr = PWR_OFF; // RULE9
            end
          end else begin
            s_d.wdt_cnt = s_q.wdt_cnt + 32'h0000_0001;
          end
        end
      end
      PWR_CYCLE: begin
        if (tick) begin
          if (s_q.off_cnt >= OFF_TICKS - 1) begin
            s_d.pwr = PWR_ON; // RULE1
            s_d.off_cnt = '0;
          end else begin
            s_d.off_cnt = s_q.off_cnt + 32'h0000_0001;
          end
        end
      end
      default: s_d.pwr = PWR_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign host_power_on = s_q.pwr == PWR_ON;
  assign led_power = (s_q.pwr == PWR_ON) ? 1'b1 : s_q.flash_ph; // RULE7
  assign led_boot = (s_q.pwr == PWR_ON) ? !s_q.boot_off : !s_q.flash_ph; // RULE7

  sequence fan1_write_s;
    bus.wr && bus.addr == ADDR_FAN1;
  endsequence

  sequence fan0_write_s;
    bus.wr && bus.addr == ADDR_FAN0;
  endsequence

  keepalive_clear_a: assert property ( // RULE10
    @(posedge sys_clk) disable iff (reset)
    keepalive_wr |=> s_q.wdt_cnt == 0 && s_q.attempts == 0)
    else $error("keep-alive did not restart the timeout");

  supv_disabled_a: assert property ( // RULE3
    @(posedge sys_clk) disable iff (reset)
    !supv_on && s_q.pwr == PWR_ON |=> s_q.pwr != PWR_CYCLE && s_q.wdt_cnt == 0)
    else $error("timeout ran with supervision disabled");

  timeout_cycle_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr == PWR_ON && supv_on && !keepalive_wr && timeout &&
    s_q.attempts <= {1'b0, max_attempts}
    |=> s_q.pwr == PWR_CYCLE && !host_power_on)
    else $error("expired timeout did not power-cycle host");

  retry_limit_a: assert property ( // RULE9
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr == PWR_ON && supv_on && !keepalive_wr && timeout &&
    s_q.attempts > {1'b0, max_attempts} |=> s_q.pwr == PWR_OFF)
    else $error("retry limit not honoured");

  joint_ignore_a: assert property ( // RULE5
    @(posedge sys_clk) disable iff (reset)
    fan1_write_s and s_q.fan_joint |=> $stable(s_q.fan1))
    else $error("fan 1 write accepted in joint mode");

  joint_both_a: assert property ( // RULE5
    @(posedge sys_clk) disable iff (reset)
    fan0_write_s and s_q.fan_joint
    |=> s_q.fan0 == $past(bus.wdata[2:0]) && s_q.fan1 == s_q.fan0)
    else $error("joint fan write did not set both channels");

  separate_fan_a: assert property ( // RULE12
    @(posedge sys_clk) disable iff (reset)
    fan1_write_s and !s_q.fan_joint |=> s_q.fan1 == $past(bus.wdata[2:0]))
    else $error("separate fan 1 write lost");

  flash_alt_a: assert property ( // RULE7
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr != PWR_ON |-> led_power != led_boot)
    else $error("indicators not alternating while host off");

  restore_always_a: assert property ( // RULE8
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr == PWR_START && s_q.start_cnt == START_WAIT &&
    s_q.pwr_mgt[1:0] == 2'b11 |=> host_power_on)
    else $error("host not restored with setting 0x03");

  restore_off_a: assert property ( // RULE11
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr == PWR_START && s_q.start_cnt == START_WAIT &&
    !s_q.pwr_mgt[RESTORE_ENABLE_BIT] |=> s_q.pwr == PWR_OFF)
    else $error("host restored with restore disabled");

  // Last tick of the off time; the host must come back on the next edge
  sequence off_done_s;
    s_q.pwr == PWR_CYCLE && tick && s_q.off_cnt >= OFF_TICKS - 1;
  endsequence

  flash_toggle_a: assert property ( // RULE7
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr != PWR_ON && tick && s_q.flash_cnt >= FLASH_TICKS - 1
    |=> host_power_on || led_power != $past(led_power))
    else $error("indicators stopped flashing while host off");

  cycle_restore_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (reset)
    off_done_s |=> host_power_on && s_q.wdt_cnt == 0)
    else $error("host not powered again after power-cycle");

  keepalive_read_a: assert property ( // RULE10
    @(posedge sys_clk) disable iff (reset)
    bus.rd && bus.addr == ADDR_KEEPALIVE |=> bus_rdata == READ_CMD_VAL)
    else $error("keep-alive command read did not return all ones");

  supv_write_a: assert property ( // RULE3 RULE9
    @(posedge sys_clk) disable iff (reset)
    bus.wr && bus.addr == ADDR_SUPV
    |=> supv_on == $past(bus.wdata[SUPERVISION_ENABLE_BIT]) &&
        max_attempts == $past(bus.wdata[6:0]))
    else $error("supervision control write not taken");

  joint_mode_a: assert property ( // RULE12
    @(posedge sys_clk) disable iff (reset)
    bus.wr && bus.addr == ADDR_FAN_MODE
    |=> s_q.fan_joint == $past(bus.wdata[FAN_JOINT_MODE_BIT]))
    else $error("fan joint-mode bit not taken");

  restore_cond_a: assert property ( // RULE11
    @(posedge sys_clk) disable iff (reset)
    s_q.pwr == PWR_START && s_q.start_cnt == START_WAIT && s_q.pwr_mgt[1:0] == 2'b01
    |=> host_power_on == $past(s_q.last_s2))
    else $error("conditional restore did not follow the strap");
endmodule

// ==== verification/hps_host_model.sv ====
// Host software model: register bus master sending commands and keep-alives
`timescale 1ns/100ps
module hps_host_model
  import hps_pkg::*;
(
  input wire logic sys_clk, // System clock
  output hps_bus_s bus, // Register bus request
  input wire logic [7:0] bus_rdata // Read data
);
  initial bus = '0;
  // Released address and data show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '{~a, 8'hff, 1'b0, 1'b0};
    #1 d = bus_rdata;
  endtask
  task automatic keep_alive(input int n, input int gap);
    repeat (n) begin
      wr(ADDR_KEEPALIVE, 8'h5a);
      repeat (gap) @(posedge sys_clk);
    end
  endtask
endmodule

// ==== verification/hps_supervisor_tb_top.sv ====
// Self-checking bench for the host power supervisor
`timescale 1ns/100ps
module hps_supervisor_tb_top;
  import hps_pkg::*;
  logic sys_clk;
  logic reset;
  logic power_button;
  logic last_on_pin;
  hps_bus_s bus;
  logic [7:0] bus_rdata;
  logic host_power_on;
  logic led_power;
  logic led_boot;
  hps_fan_s fan;
  int err_count;
  int n_checks;
  logic [31:0] seed;
  logic [7:0] rv;
  logic [7:0] rw;
  logic [7:0] a;
  logic [7:0] pm_tab [4] = '{8'h03, 8'h01, 8'h01, 8'h02};

  hps_supervisor #(.TICK_DIV(4), .TIMEOUT_TICKS(5), .OFF_TICKS(3), .FLASH_TICKS(2))
    i_hps_supervisor (.sys_clk(sys_clk), .reset(reset), .bus(bus), .bus_rdata(bus_rdata),
    .power_button(power_button), .last_on_pin(last_on_pin), .host_power_on(host_power_on),
    .led_power(led_power), .led_boot(led_boot), .fan(fan));
  hps_host_model i_hps_host_model (.sys_clk(sys_clk), .bus(bus), .bus_rdata(bus_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic exp_restore(input logic [7:0] pm, input logic last);
    return pm[0] & (pm[1] | last);
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    i_hps_host_model.rd(ad, rv);
    chk8("read data", e, rv);
    @(posedge sys_clk);
    #1 chk8("read data idle", READ_UNMAPPED, bus_rdata);
  endtask
  task automatic wait_pwr(input logic v, input int m);
    for (int i = 0; i < m && host_power_on !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk1("host_power_on", v, host_power_on);
  endtask
  task automatic hold_pwr(input logic v, input int m);
    logic ok;
    ok = 1'b1;
    repeat (m) begin
      @(posedge sys_clk);
      #1 ok &= (host_power_on === v);
    end
    chk1("host_power_on held", 1'b1, ok);
  endtask
  // Needs at least two toggles so a stuck indicator pair cannot pass
  task automatic flash_chk(input int m);
    logic ok;
    logic p;
    int t;
    ok = 1'b1;
    p = led_power;
    t = 0;
    repeat (m) begin
      @(posedge sys_clk);
      #1 ok &= (led_boot === ~led_power);
      t += int'(led_power !== p);
      p = led_power;
    end
    chk1("indicators alternate", 1'b1, ok && t > 1);
  endtask
  task automatic fan_chk(input logic e0, input logic e1);
    repeat (250) @(posedge sys_clk);
    repeat (4) begin
      repeat (37) @(posedge sys_clk);
      #1 chk1("fan0", e0, fan.fan0_pwm);
      chk1("fan1", e1, fan.fan1_pwm);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h1f6e;
    err_count = 0;
    n_checks = 0;
    power_button = 1'b0;
    last_on_pin = 1'b0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(ADDR_PWR_MGT, PWR_MGT_RST);
    rchk(ADDR_SUPV, SUPV_RST);
    rchk(ADDR_FAN_MODE, 8'h01);
    rchk(ADDR_FAN0, 8'h04);
    rchk(ADDR_FAN1, 8'h04);
    rchk(ADDR_KEEPALIVE, READ_CMD_VAL);
    rchk(ADDR_BOOT_OK, READ_CMD_VAL);
    rchk(8'h40, READ_UNMAPPED);
    flash_chk(40);
    fan_chk(1'b1, 1'b1);
    i_hps_host_model.wr(ADDR_FAN0, 8'h00);
    i_hps_host_model.wr(ADDR_FAN1, 8'h04);
    rchk(ADDR_FAN1, 8'h00);
    fan_chk(1'b0, 1'b0);
    i_hps_host_model.wr(ADDR_FAN_MODE, 8'h00);
    i_hps_host_model.wr(ADDR_FAN1, 8'h07);
    fan_chk(1'b0, 1'b1);
    for (int n = 0; n < 8; n++) begin
      rw = xs();
      a = ADDR_FAN0 + 8'(n % 2);
      i_hps_host_model.wr(a, rw);
      rchk(a, {5'h00, rw[2:0]});
    end
    @(posedge sys_clk);
    power_button <= 1'b1;
    wait_pwr(1'b1, 20);
    @(posedge sys_clk);
    power_button <= 1'b0;
    hold_pwr(1'b1, 100);
    rchk(ADDR_STATUS, 8'h80);
    i_hps_host_model.wr(ADDR_BOOT_OK, 8'h00);
    @(posedge sys_clk);
    #1 chk1("led_boot on", 1'b1, led_boot);
    chk1("led_power on", 1'b1, led_power);
    i_hps_host_model.wr(ADDR_BOOT_OK, 8'h01);
    @(posedge sys_clk);
    #1 chk1("led_boot off", 1'b0, led_boot);
    i_hps_host_model.wr(ADDR_SUPV, 8'h80);
    fork
      i_hps_host_model.keep_alive(8, 10);
      hold_pwr(1'b1, 100);
    join
    wait_pwr(1'b0, 30);
    wait_pwr(1'b1, 30);
    wait_pwr(1'b0, 40);
    hold_pwr(1'b0, 60);
    rchk(ADDR_STATUS, 8'h01);
    for (int n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      last_on_pin <= (n == 1);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      i_hps_host_model.wr(ADDR_PWR_MGT, pm_tab[n]);
      repeat (12) @(posedge sys_clk);
      #1 chk1("restore", exp_restore(pm_tab[n], n == 1), host_power_on);
    end
    tally_and_finish();
  end
endmodule
